// ### jnp_prog_path.sv
// JTAG programming path: test data registers on the test clock, memory side on i_clk.
// Assumes an outside TAP controller giving the instruction and one-tck state strobes.
`timescale 1ns/1ps
`default_nettype none

module jnp_prog_path #(
  parameter int TIMEOUT_SHORT = 64,
  parameter int TIMEOUT_LONG  = 8192
) (
  // System clock domain.
  input  wire  logic              i_clk,
  input  wire  logic              i_reset,
  input  wire  logic              i_long_timeout,
  // Test clock domain from the TAP controller.
  input  wire  logic              i_tck,
  input  wire  logic              i_tck_reset,
  input  wire  logic [3:0]        i_ir,
  input  wire  logic              i_capture_dr,
  input  wire  logic              i_shift_dr,
  input  wire  logic              i_update_dr,
  input  wire  logic              i_run_idle,
  input  wire  logic              i_tdi,
  output logic                    o_tdo,
  // Memory programming side.
  input  wire  logic              i_nvm_busy,
  input  wire  logic [15:0]       i_nvm_rdata,
  output logic [14:0]             o_nvm_cmd,
  output logic                    o_nvm_exec,
  output logic                    o_nvm_latch,
  output var jnp_pkg::jnp_mode_t  o_nvm_mode,
  output logic [15:0]             o_nvm_addr,
  output logic [15:0]             o_nvm_data,
  // Page buffer direct load.
  output logic                    o_pbuf_we,
  output logic                    o_pbuf_hi,
  output logic [15:0]             o_pbuf_addr,
  output logic [7:0]              o_pbuf_byte,
  // Part control.
  output logic                    o_part_reset,
  output logic                    o_prog_enabled
);

  localparam int TO_W = $clog2(TIMEOUT_LONG + 1);

  // Test clock domain state.
  logic [14:0]        cmd_sr;
  logic [14:0]        next_cmd_sr;
  logic [15:0]        en_sr;
  logic [15:0]        next_en_sr;
  logic [15:0]        en_latched;
  logic               rst_bit;
  logic               next_rst_bit;
  logic               prog_en;
  logic [14:0]        cmd_app;
  logic               armed;
  logic               upd_tgl;
  logic               exec_tgl;
  logic               load_tgl;
  logic               radv_tgl;
  jnp_pkg::jnp_load_t load_pay;
  logic               ld_hi;
  logic               ld_first;
  logic               rd_hi;
  logic               req_s1;
  logic               req_s2;
  logic               req_s3;
  logic               req_acc;
  logic               ack_tgl;
  jnp_pkg::jnp_back_t back;
  logic               in_cmd;
  logic               in_pload;
  logic               in_pread;

  // System clock domain state.
  logic [jnp_pkg::X_W-1:0] xin;
  logic [jnp_pkg::X_W-1:0] sy1;
  logic [jnp_pkg::X_W-1:0] sy2;
  logic [jnp_pkg::X_W-1:0] sy3;
  logic [jnp_pkg::X_W-1:0] acc;
  logic [jnp_pkg::X_W-1:0] acc_d;
  logic [jnp_pkg::X_W-1:0] ev;
  logic [TO_W-1:0]         to_cnt;
  logic                    req_tgl;
  jnp_pkg::jnp_back_t      back_hold;
  logic [6:0]              ctrl;

  assign in_cmd   = (i_ir == jnp_pkg::IR_CMD) && prog_en;
  assign in_pload = (i_ir == jnp_pkg::IR_PLOAD) && prog_en;
  assign in_pread = (i_ir == jnp_pkg::IR_PREAD) && prog_en;
  assign prog_en  = (en_latched == jnp_pkg::ENABLE_KEY);

  // Next values of the shift chains, shifted least significant bit first.
  always_comb begin
    next_cmd_sr  = cmd_sr;
    next_en_sr   = en_sr;
    next_rst_bit = rst_bit;
    if (in_cmd && i_capture_dr) begin
      next_cmd_sr = back.result;
    end else if (in_pread && i_capture_dr) begin
      next_cmd_sr[7:0] = rd_hi ? back.word[15:8] : back.word[7:0];
    end else if (in_cmd && i_shift_dr) begin
      next_cmd_sr = {i_tdi, cmd_sr[14:1]};
    end else if ((in_pload || in_pread) && i_shift_dr) begin
      next_cmd_sr[7:0] = {i_tdi, cmd_sr[7:1]};
    end
    if ((i_ir == jnp_pkg::IR_ENABLE) && i_shift_dr) begin
      next_en_sr = {i_tdi, en_sr[15:1]};
    end
    if ((i_ir == jnp_pkg::IR_RESET) && i_shift_dr) begin
      next_rst_bit = i_tdi;
    end
  end

  // Shift chains and data out.
  always_ff @(posedge i_tck) begin
    if (i_tck_reset) begin
      cmd_sr  <= jnp_pkg::CMD_RST;
      en_sr   <= jnp_pkg::ENABLE_RST;
      rst_bit <= 1'b0;
      o_tdo   <= 1'b0;
    end else begin
      cmd_sr  <= next_cmd_sr;
      en_sr   <= next_en_sr;
      rst_bit <= next_rst_bit;
      case (i_ir)
        jnp_pkg::IR_ENABLE: o_tdo <= next_en_sr[0];
        jnp_pkg::IR_RESET:  o_tdo <= next_rst_bit;
        default:            o_tdo <= next_cmd_sr[0];
      endcase
    end
  end

  // Enable register compared against the key at Update-DR.
  always_ff @(posedge i_tck) begin
    if (i_tck_reset) begin
      en_latched <= jnp_pkg::ENABLE_RST;
    end else if ((i_ir == jnp_pkg::IR_ENABLE) && i_update_dr) begin
      en_latched <= en_sr;
    end
  end

  // Command update and the single execute clock.
  always_ff @(posedge i_tck) begin
    if (i_tck_reset) begin
      cmd_app  <= jnp_pkg::CMD_RST;
      armed    <= 1'b0;
      upd_tgl  <= 1'b0;
      exec_tgl <= 1'b0;
    end else if (in_cmd && i_update_dr) begin
      cmd_app <= cmd_sr;
      upd_tgl <= ~upd_tgl;
      armed   <= 1'b1;
    end else if (in_cmd && i_run_idle && armed) begin
      exec_tgl <= ~exec_tgl;
      armed    <= 1'b0;
    end
  end

  // Page load sequencing.
  always_ff @(posedge i_tck) begin
    if (i_tck_reset) begin
      load_pay <= '0;
      load_tgl <= 1'b0;
      ld_hi    <= 1'b0;
      ld_first <= 1'b1;
    end else if (!in_pload) begin
      ld_hi    <= 1'b0;
      ld_first <= 1'b1;
    end else if (i_update_dr) begin
      load_pay <= '{hi: ld_hi, first: ld_first, data: cmd_sr[7:0]};
      load_tgl <= ~load_tgl;
      ld_hi    <= ~ld_hi;
      ld_first <= 1'b0;
    end
  end

  // Page read sequencing.
  always_ff @(posedge i_tck) begin
    if (i_tck_reset) begin
      rd_hi    <= 1'b0;
      radv_tgl <= 1'b0;
    end else if (!in_pread) begin
      rd_hi <= 1'b0;
    end else if (i_capture_dr) begin
      rd_hi <= ~rd_hi;
      if (rd_hi) begin
        radv_tgl <= ~radv_tgl;
      end
    end
  end

  // Receiver of the result and read word from the system clock.
  always_ff @(posedge i_tck) begin
    if (i_tck_reset) begin
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      req_s3  <= 1'b0;
      req_acc <= 1'b0;
      ack_tgl <= 1'b0;
      back    <= '0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_s2 == req_s3) begin
        req_acc <= req_s3;
      end
      if (req_acc != ack_tgl) begin
        back    <= back_hold;
        ack_tgl <= req_acc;
      end
    end
  end

  // Crossing of events and levels into the system clock.
  assign xin = {ack_tgl, prog_en, rst_bit, radv_tgl, load_tgl, exec_tgl, upd_tgl};
  assign ev  = acc ^ acc_d;

  for (genvar g = 0; g < jnp_pkg::X_W; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        sy1[g]   <= 1'b0;
        sy2[g]   <= 1'b0;
        sy3[g]   <= 1'b0;
        acc[g]   <= 1'b0;
        acc_d[g] <= 1'b0;
      end else begin
        sy1[g] <= xin[g];
        sy2[g] <= sy1[g];
        sy3[g] <= sy2[g];
        if (sy2[g] == sy3[g]) begin
          acc[g] <= sy3[g];
        end
        acc_d[g] <= acc[g];
      end
    end
  end

  // Part reset with time-out after release.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      to_cnt         <= '0;
      o_part_reset   <= 1'b0;
      o_prog_enabled <= 1'b0;
    end else begin
      if (acc[jnp_pkg::X_RST]) begin
        to_cnt <= i_long_timeout ? TO_W'(TIMEOUT_LONG) : TO_W'(TIMEOUT_SHORT);
      end else if (to_cnt != '0) begin
        to_cnt <= to_cnt - 1'b1;
      end
      o_part_reset <= acc[jnp_pkg::X_RST] || (to_cnt != '0);
      o_prog_enabled <= acc[jnp_pkg::X_EN];
    end
  end

  assign ctrl = o_nvm_cmd[14:jnp_pkg::CTRL_LSB];

  // Applied command, execute and latch strobes, mode and data decode.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_nvm_cmd   <= jnp_pkg::CMD_RST;
      o_nvm_exec  <= 1'b0;
      o_nvm_latch <= 1'b0;
      o_nvm_mode  <= jnp_pkg::MODE_NONE;
      o_nvm_data  <= '0;
    end else begin
      o_nvm_exec  <= ev[jnp_pkg::X_EXEC];
      o_nvm_latch <= ev[jnp_pkg::X_UPD] && cmd_app[jnp_pkg::LATCH_BIT];
      if (ev[jnp_pkg::X_UPD]) begin
        o_nvm_cmd <= cmd_app;
        if (cmd_app[14:8] == jnp_pkg::CTRL_ENTER) begin
          case (cmd_app[7:0])
            jnp_pkg::OP_ERASE:  o_nvm_mode <= jnp_pkg::MODE_ERASE;
            jnp_pkg::OP_FWRITE: o_nvm_mode <= jnp_pkg::MODE_FWRITE;
            jnp_pkg::OP_FREAD:  o_nvm_mode <= jnp_pkg::MODE_FREAD;
            jnp_pkg::OP_EWRITE: o_nvm_mode <= jnp_pkg::MODE_EWRITE;
            jnp_pkg::OP_EREAD:  o_nvm_mode <= jnp_pkg::MODE_EREAD;
            default:            o_nvm_mode <= jnp_pkg::MODE_NONE;
          endcase
        end else if (cmd_app[14:8] == jnp_pkg::CTRL_DATA_LO) begin
          o_nvm_data[7:0] <= cmd_app[7:0];
        end else if (cmd_app[14:8] == jnp_pkg::CTRL_DATA_HI) begin
          o_nvm_data[15:8] <= cmd_app[7:0];
        end
      end
    end
  end

  // Word address counter and direct page buffer writes.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_nvm_addr  <= jnp_pkg::ADDR_RST;
      o_pbuf_we   <= 1'b0;
      o_pbuf_hi   <= 1'b0;
      o_pbuf_addr <= jnp_pkg::ADDR_RST;
      o_pbuf_byte <= '0;
    end else begin
      o_pbuf_we <= ev[jnp_pkg::X_LOAD];
      if (ev[jnp_pkg::X_UPD] && (cmd_app[14:8] == jnp_pkg::CTRL_ADDR_HI)) begin
        o_nvm_addr[15:8] <= cmd_app[7:0];
      end else if (ev[jnp_pkg::X_UPD] && (cmd_app[14:8] == jnp_pkg::CTRL_ADDR_LO)) begin
        o_nvm_addr[7:0] <= cmd_app[7:0];
      end else if (ev[jnp_pkg::X_LOAD]) begin
        o_pbuf_hi   <= load_pay.hi;
        o_pbuf_byte <= load_pay.data;
        if (!load_pay.hi && !load_pay.first) begin
          o_nvm_addr  <= o_nvm_addr + 16'h0001;
          o_pbuf_addr <= o_nvm_addr + 16'h0001;
        end else begin
          o_pbuf_addr <= o_nvm_addr;
        end
      end else if (ev[jnp_pkg::X_RADV]) begin
        o_nvm_addr <= o_nvm_addr + 16'h0001;
      end
    end
  end

  // Result and read word offered to the test clock by toggle handshake.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      req_tgl   <= 1'b0;
      back_hold <= '0;
    end else if (acc[jnp_pkg::X_ACK] == req_tgl) begin
      back_hold.result <= '0;
      back_hold.result[jnp_pkg::READY_BIT] <= ~i_nvm_busy;
      back_hold.result[7:0] <= (ctrl == jnp_pkg::CTRL_RD_HI) ?
                               i_nvm_rdata[15:8] : i_nvm_rdata[7:0];
      back_hold.word <= i_nvm_rdata;
      req_tgl        <= ~req_tgl;
    end
  end

endmodule : jnp_prog_path

`default_nettype wire

// ### jnp_pkg.sv
// Constants and carrier types for the JTAG memory programming path.
// Assumes a TAP controller outside that supplies the instruction and state strobes.
package jnp_pkg;

  // Instruction register codes.
  localparam logic [3:0] IR_ENABLE = 4'h4;
  localparam logic [3:0] IR_CMD    = 4'h5;
  localparam logic [3:0] IR_PLOAD  = 4'h6;
  localparam logic [3:0] IR_PREAD  = 4'h7;
  localparam logic [3:0] IR_RESET  = 4'hC;

  // Register widths and the enable key.
  localparam int          CMD_W      = 15;
  localparam int          CTRL_LSB   = 8;
  localparam int          EN_W       = 16;
  localparam logic [15:0] ENABLE_KEY = 16'hA370;
  localparam logic [15:0] ENABLE_RST = 16'h0000;

  // Control codes in the upper seven command bits.
  localparam logic [6:0] CTRL_ENTER   = 7'h23;
  localparam logic [6:0] CTRL_ADDR_HI = 7'h07;
  localparam logic [6:0] CTRL_ADDR_LO = 7'h03;
  localparam logic [6:0] CTRL_DATA_LO = 7'h13;
  localparam logic [6:0] CTRL_DATA_HI = 7'h17;
  localparam logic [6:0] CTRL_RD_LO   = 7'h36;
  localparam logic [6:0] CTRL_RD_HI   = 7'h37;

  // Operands of the enter command.
  localparam logic [7:0] OP_ERASE  = 8'h80;
  localparam logic [7:0] OP_FWRITE = 8'h10;
  localparam logic [7:0] OP_FREAD  = 8'h02;
  localparam logic [7:0] OP_EWRITE = 8'h11;
  localparam logic [7:0] OP_EREAD  = 8'h03;

  // Field positions in the command and result words.
  localparam int READY_BIT = 9;
  localparam int LATCH_BIT = 14;

  // Page buffer write deadline in test clock cycles.
  localparam int PBUF_LIMIT_TCK = 11;

  // Positions in the vector crossing from the test clock to the system clock.
  localparam int X_UPD  = 0;
  localparam int X_EXEC = 1;
  localparam int X_LOAD = 2;
  localparam int X_RADV = 3;
  localparam int X_RST  = 4;
  localparam int X_EN   = 5;
  localparam int X_ACK  = 6;
  localparam int X_W    = 7;

  // Reset values.
  localparam logic [14:0] CMD_RST  = 15'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_ERASE,
    MODE_FWRITE,
    MODE_FREAD,
    MODE_EWRITE,
    MODE_EREAD
  } jnp_mode_t;

  typedef struct packed {
    logic [14:0] result;
    logic [15:0] word;
  } jnp_back_t;

  typedef struct packed {
    logic       hi;
    logic       first;
    logic [7:0] data;
  } jnp_load_t;

endpackage : jnp_pkg

// ### jnp_monitor.sv
// Checker on the system clock side of the programming path.
// Assumes it is bound to jnp_prog_path and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module jnp_monitor #(
  parameter int TIMEOUT_SHORT = 64
) (
  // Clock and reset.
  input wire logic               i_clk,
  input wire logic               i_reset,
  // Watched outputs.
  input wire logic [14:0]        o_nvm_cmd,
  input wire logic               o_nvm_exec,
  input wire logic               o_nvm_latch,
  input wire jnp_pkg::jnp_mode_t o_nvm_mode,
  input wire logic [15:0]        o_nvm_addr,
  input wire logic               o_pbuf_we,
  input wire logic               o_pbuf_hi,
  input wire logic [15:0]        o_pbuf_addr,
  input wire logic               o_part_reset,
  input wire logic               o_prog_enabled
);
  logic [15:0] lo_addr;
  logic        last_hi;
  logic [15:0] hold;

  default clocking cb @(posedge i_clk);
  endclocking

  // Remembers the previous page buffer write.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      last_hi <= 1'b1;
    end else if (o_pbuf_we) begin
      last_hi <= o_pbuf_hi;
      lo_addr <= o_pbuf_addr;
    end
  end

  // Counts the cycles that the part reset has been held.
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_part_reset) begin
      hold <= 16'h0000;
    end else if (hold != 16'hFFFF) begin
      hold <= hold + 16'h0001;
    end
  end

  reset_clear_a: assert property (
    i_reset |=> o_nvm_mode == jnp_pkg::MODE_NONE && !o_nvm_exec && !o_pbuf_we
      && o_nvm_addr == jnp_pkg::ADDR_RST) else $error("outputs not cleared by reset");
  exec_pulse_a: assert property (
    disable iff (i_reset) o_nvm_exec |=> !o_nvm_exec) else $error("long execute strobe");
  latch_bit_a: assert property (
    disable iff (i_reset) o_nvm_latch |-> ##[0:2] o_nvm_cmd[14])
    else $error("latch without top bit");
  mode_enter_a: assert property (
    disable iff (i_reset) !$past(i_reset) && !$stable(o_nvm_mode)
      |-> ##[0:2] o_nvm_cmd[14:8] == jnp_pkg::CTRL_ENTER) else $error("mode change without enter");
  pbuf_pulse_a: assert property (
    disable iff (i_reset) o_pbuf_we |=> !o_pbuf_we) else $error("long buffer write");
  byte_alt_a: assert property (
    disable iff (i_reset) o_pbuf_we |-> o_pbuf_hi != last_hi) else $error("bytes not alternating");
  hi_addr_a: assert property (
    disable iff (i_reset) o_pbuf_we && o_pbuf_hi |-> o_pbuf_addr == lo_addr)
    else $error("high byte address moved");
  load_enabled_a: assert property (
    disable iff (i_reset) o_pbuf_we |-> o_prog_enabled) else $error("load while disabled");
  reset_hold_a: assert property (
    disable iff (i_reset) !$past(i_reset) && $fell(o_part_reset) |-> hold >= TIMEOUT_SHORT)
    else $error("part reset too short");
endmodule : jnp_monitor

bind jnp_prog_path jnp_monitor #(.TIMEOUT_SHORT(TIMEOUT_SHORT)) u_mon (
  .i_clk(i_clk), .i_reset(i_reset), .o_nvm_cmd(o_nvm_cmd), .o_nvm_exec(o_nvm_exec),
  .o_nvm_latch(o_nvm_latch), .o_nvm_mode(o_nvm_mode), .o_nvm_addr(o_nvm_addr),
  .o_pbuf_we(o_pbuf_we), .o_pbuf_hi(o_pbuf_hi), .o_pbuf_addr(o_pbuf_addr),
  .o_part_reset(o_part_reset), .o_prog_enabled(o_prog_enabled));

`default_nettype wire

// ### jnp_tap_model.sv
// Programmer model driving the test access port of the programming path.
// Assumes one caller at a time; the test clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none

module jnp_tap_model (
  // Test port; o_st is capture, shift, update, idle, data in.
  output logic       o_tck,
  output logic       o_tck_reset,
  output logic [3:0] o_ir,
  output logic [4:0] o_st,
  input  wire  logic i_tdo
);
  realtime t_sh;

  initial begin
    o_tck = 1'b0;
    o_tck_reset = 1'b1;
    o_ir = 4'h0;
    o_st = 5'h00;
  end

  // One test clock period; strobes change while the clock is low.
  task automatic tick(input logic [4:0] s);
    o_st = s;
    #15 o_tck = 1'b1;
    if (s[3]) t_sh = $realtime;
    #15 o_tck = 1'b0;
  endtask : tick

  // Power-on reset of the test clock domain.
  task automatic por();
    repeat (2) tick(5'h00);
    o_tck_reset = 1'b0;
  endtask : por

  // Clock periods with no strobe, not even idle; the data line toggles since nobody reads it.
  task automatic gap(input int n);
    repeat (n) tick({4'h0, ~o_st[0]});
  endtask : gap

  // Capture, shift n bits, update, then two idle clocks if asked.
  task automatic scan(input logic [3:0] ir, input int n, input logic [15:0] d,
                      input bit run, output logic [15:0] q);
    q = 16'h0000;
    o_ir = ir;
    tick({4'h8, ~o_st[0]});
    for (int i = 0; i < n; i++) begin
      q[i] = i_tdo;
      tick({4'h4, d[i]});
    end
    tick({4'h2, ~d[n-1]});
    if (run) repeat (2) tick({4'h1, d[n-1]});
  endtask : scan
endmodule : jnp_tap_model

`default_nettype wire

// ### testbench.sv
// Self-checking bench of the programming path with a programmer model on the test port.
// Assumes short time-outs of 4 and 8; memory returns address xor a random key.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic               i_clk, i_reset, i_long_timeout, busy, tck, tck_rst, tdo;
  logic               exec, latch, we, hi, prst, pen;
  logic [3:0]         ir;
  logic [4:0]         st;
  logic [14:0]        cmd_o;
  logic [15:0]        rdata, addr, data, paddr, key, a, r, w;
  logic [7:0]         pbyte, b;
  jnp_pkg::jnp_mode_t mode;
  int                 n_mismatch, n_tests, n_exec, n_latch, n_run, c;
  realtime            t_fall;
  logic [24:0]        exp_q[$];
  logic [7:0]         ops[5] = '{jnp_pkg::OP_ERASE, jnp_pkg::OP_FWRITE,
                               jnp_pkg::OP_FREAD, jnp_pkg::OP_EWRITE, jnp_pkg::OP_EREAD};
  jnp_pkg::jnp_mode_t mds[5] = '{jnp_pkg::MODE_ERASE, jnp_pkg::MODE_FWRITE,
                               jnp_pkg::MODE_FREAD, jnp_pkg::MODE_EWRITE, jnp_pkg::MODE_EREAD};

  jnp_prog_path #(.TIMEOUT_SHORT(4), .TIMEOUT_LONG(8)) DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_long_timeout(i_long_timeout), .i_tck(tck),
    .i_tck_reset(tck_rst), .i_ir(ir), .i_capture_dr(st[4]), .i_shift_dr(st[3]),
    .i_update_dr(st[2]), .i_run_idle(st[1]), .i_tdi(st[0]), .o_tdo(tdo),
    .i_nvm_busy(busy), .i_nvm_rdata(rdata), .o_nvm_cmd(cmd_o), .o_nvm_exec(exec),
    .o_nvm_latch(latch), .o_nvm_mode(mode), .o_nvm_addr(addr), .o_nvm_data(data),
    .o_pbuf_we(we), .o_pbuf_hi(hi), .o_pbuf_addr(paddr), .o_pbuf_byte(pbyte),
    .o_part_reset(prst), .o_prog_enabled(pen));

  jnp_tap_model prog (.o_tck(tck), .o_tck_reset(tck_rst), .o_ir(ir), .o_st(st), .i_tdo(tdo));

  task automatic bad(input string m);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : bad

  task automatic chk(input logic [24:0] g, input logic [24:0] e, input string m);
    n_tests++;
    if (g !== e) bad(m);
  endtask : chk

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic cmd(input logic [14:0] x);
    n_run++;
    prog.scan(jnp_pkg::IR_CMD, 15, {1'b0, x}, 1'b1, r);
    prog.gap(10);
  endtask : cmd

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  always @(negedge i_clk) rdata <= addr ^ key;
  always @(negedge prst) t_fall = $realtime;

  // Takes the oldest noted buffer write whenever one appears.
  always @(negedge i_clk) begin
    if (exec === 1'b1) n_exec++;
    if (latch === 1'b1) n_latch++;
    if (we === 1'b1) begin
      if (exp_q.size() == 0) bad("unexpected buffer write");
      else chk({hi, paddr, pbyte}, exp_q.pop_front(), "buffer write");
    end
  end

  initial begin
    #100000;
    bad("timeout");
    results();
  end

  initial begin
    {i_reset, i_long_timeout, busy} = 3'b100;
    {n_mismatch, n_tests, n_exec, n_latch, n_run} = '0;
    void'($urandom(32'h5D64));
    key = 16'($urandom);
    a = 16'($urandom) & 16'hFFF0;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk) i_reset = 1'b0;
    prog.por();
    chk(25'(pen), 25'h0, "enabled after power-on");
    cmd({jnp_pkg::CTRL_ENTER, jnp_pkg::OP_FREAD});
    chk(25'(cmd_o), 25'(jnp_pkg::CMD_RST), "command taken while disabled");
    n_run = 0;
    for (int t = 0; t < 2; t++) begin
      @(negedge i_clk) i_long_timeout = t[0];
      prog.scan(jnp_pkg::IR_RESET, 1, 16'h0001, 1'b0, r);
      chk(25'(prst), 25'h1, "part reset not taken");
      prog.gap(4);
      prog.scan(jnp_pkg::IR_RESET, 1, 16'h0000, 1'b0, r);
      prog.gap(4);
      c = int'((t_fall - prog.t_sh) / 4.0);
      chk(25'(c >= 6 + 4 * t && c <= 12 + 4 * t), 25'h1, "reset time-out length");
    end
    prog.scan(jnp_pkg::IR_RESET, 1, 16'h0001, 1'b0, r);
    prog.scan(jnp_pkg::IR_ENABLE, 16, jnp_pkg::ENABLE_KEY ^ 16'h0001, 1'b0, r);
    prog.gap(4);
    chk(25'(pen), 25'h0, "near key accepted");
    prog.scan(jnp_pkg::IR_ENABLE, 16, jnp_pkg::ENABLE_KEY, 1'b0, r);
    prog.gap(4);
    chk(25'(pen), 25'h1, "key refused");
    for (int i = 0; i < 5; i++) begin
      cmd({jnp_pkg::CTRL_ENTER, ops[i]});
      chk(25'(mode), 25'(mds[i]), "mode after enter");
      chk(25'(cmd_o), 25'({jnp_pkg::CTRL_ENTER, ops[i]}), "applied word");
    end
    cmd({jnp_pkg::CTRL_ENTER, 8'h04});
    chk(25'(mode), 25'(jnp_pkg::MODE_NONE), "unknown enter operand");
    cmd(15'h2380);
    cmd(15'h3180);
    @(negedge i_clk) busy = 1'b1;
    repeat (3) cmd(15'h3380);
    chk(25'(r[jnp_pkg::READY_BIT]), 25'h0, "ready while busy");
    @(negedge i_clk) busy = 1'b0;
    for (int k = 0; k < 4 && r[jnp_pkg::READY_BIT] !== 1'b1; k++) cmd(15'h3380);
    chk(25'(r[jnp_pkg::READY_BIT]), 25'h1, "never ready");
    cmd({jnp_pkg::CTRL_ENTER, jnp_pkg::OP_FWRITE});
    cmd({jnp_pkg::CTRL_ADDR_HI, a[15:8]});
    cmd({jnp_pkg::CTRL_ADDR_LO, a[7:0]});
    chk(25'(addr), 25'(a), "address load");
    cmd({jnp_pkg::CTRL_DATA_LO, key[7:0]});
    cmd({jnp_pkg::CTRL_DATA_HI, key[15:8]});
    chk(25'(data), 25'(key), "data load");
    cmd(15'h3700);
    cmd(15'h7700);
    cmd(15'h3700);
    chk(25'(n_latch), 25'h1, "latch pulses");
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      exp_q.push_back({i[0], a + 16'(i / 2), b});
      prog.scan(jnp_pkg::IR_PLOAD, 8, {8'h00, b}, 1'b0, r);
      prog.gap(11);
      chk(25'(exp_q.size()), 25'h0, "buffer write late");
    end
    chk(25'(addr), 25'(a + 16'h0001), "address after last slot");
    cmd({jnp_pkg::CTRL_ENTER, jnp_pkg::OP_FREAD});
    cmd({jnp_pkg::CTRL_ADDR_LO, a[7:0]});
    for (int i = 0; i < 4; i++) begin
      prog.scan(jnp_pkg::IR_PREAD, 8, 16'h0000, 1'b0, r);
      prog.gap(10);
      w = (a + 16'(i / 2)) ^ key;
      chk(25'(r[7:0]), 25'(i[0] ? w[15:8] : w[7:0]), "page capture");
    end
    chk(25'(addr), 25'(a + 16'h0002), "address after capture");
    cmd({jnp_pkg::CTRL_ADDR_LO, a[7:0]});
    w = a ^ key;
    cmd(15'h3600);
    cmd(15'h3700);
    chk(25'(r[7:0]), 25'(w[7:0]), "low byte read");
    cmd(15'h3700);
    chk(25'(r[7:0]), 25'(w[15:8]), "high byte read");
    chk(25'(n_exec), 25'(n_run), "execute clocks");
    prog.scan(jnp_pkg::IR_ENABLE, 16, 16'h0000, 1'b0, r);
    prog.gap(4);
    chk(25'(pen), 25'h0, "enable not cleared");
    results();
  end
endmodule : testbench

`default_nettype wire
